// File: bench/completion_queue_sleep_ctrl_tb.sv
// self-checking bench for the completion queue and sleep register group
`timescale 1ns/100ps
module completion_queue_sleep_ctrl_tb;
	logic core_clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest, seq_wr_i;
	logic external_cmdblock_ram_mode_i, host_pause_off_wr_i, dma_complete_i, phase_mismatch_i;
	logic select_out_done_i, select_in_done_i, seq_sleep_o, seq_clk_en_o;
	logic internal_io_bus_idle_o, cmdblock_in_ext_sram_o, seq_ram_stress_test_o;
	logic host_block_test_o, sequencer_block_test_o, data_fifo_test_o, scsi_block_test_o;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [7:0] seq_addr_i, seq_wdata_i, seq_rdata_o, q;
	logic [2:0] special_function_mode_o, special_function_flags_o;
	logic [4:0] st;
	int error_cnt, checks_done, i;
	assign {host_pause_off_wr_i, dma_complete_i, phase_mismatch_i, select_out_done_i,
		select_in_done_i} = st;
	cqs_regs DUT (.*);
	cqs_seq_model seq (.core_clk_i(core_clk_i), .seq_clk_en_i(seq_clk_en_o),
		.seq_wr_o(seq_wr_i), .seq_addr_o(seq_addr_i), .seq_wdata_o(seq_wdata_i));
	// 40 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one avalon transfer; held until waitrequest is sampled low at a rising edge,
	// where read data are taken before anything is released
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		@(posedge core_clk_i);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk_i);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	// one-cycle status pulse, then look after it has landed
	task automatic pulse(input logic [4:0] v);
		@(posedge core_clk_i);
		st <= v;
		@(posedge core_clk_i);
		st <= 5'h00;
		@(negedge core_clk_i);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog, well beyond the fewer than a thousand cycles the tests need
	initial begin
		#500000;
		error_cnt++;
		end_sim();
	end
	initial begin
		rst_n_i = 1'b0;
		{avs_read, avs_write, external_cmdblock_ram_mode_i} = 3'h0;
		avs_address = 10'h000;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		st = 5'h00;
		error_cnt = 0;
		checks_done = 0;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		// reset values, unmapped and read-only places
		rd(10'h070, 8'h00);
		rd(10'h274, 8'h00);
		rd(10'h27C, 8'h00);
		bus(1'b1, 10'h278, 8'h55);
		rd(10'h278, 8'h00);
		rd(10'h004, 8'h00);
		$display("test reset done");
		// internal mode: one push beyond sixteen is refused, then oldest first
		for (i = 0; i < 17; i++) seq.put(8'h9D, 8'hA0 + 8'(i));
		rd(10'h278, 8'h10);
		for (i = 0; i < 16; i++) rd(10'h274, {4'h0, 4'(i)});
		rd(10'h278, 8'h00);
		bus(1'b0, 10'h274, 8'h00);
		rd(10'h278, 8'h00);
		$display("test internal queue done");
		// external mode: full eight bits and a 255 ceiling
		@(posedge core_clk_i);
		external_cmdblock_ram_mode_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		for (i = 0; i < 256; i++) seq.put(8'h9D, 8'hF0 ^ 8'(i));
		rd(10'h278, 8'hFF);
		rd(10'h274, 8'hF0);
		rd(10'h274, 8'hF1);
		rd(10'h278, 8'hFD);
		$display("test external queue done");
		// special function: flags alone, then each test select with a mode
		bus(1'b1, 10'h27C, 8'hE0);
		rd(10'h27C, 8'hE0);
		chk({2'h0, special_function_mode_o, special_function_flags_o}, 8'h07);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, 10'h27C, 8'hA0 | (8'h01 << i));
			@(negedge core_clk_i);
			chk({3'h0, seq_ram_stress_test_o, host_block_test_o, sequencer_block_test_o,
				data_fifo_test_o, scsi_block_test_o}, 8'h01 << i);
			chk({2'h0, special_function_mode_o, special_function_flags_o}, 8'h28);
		end
		// sequencer readback: the idle address after this write is the function index
		seq.put(8'h60, 8'h00);
		repeat (2) @(negedge core_clk_i);
		chk(seq_rdata_o, 8'hB0);
		$display("test special function done");
		// sleep, wake by each status group, pause-off, inhibit
		seq.put(8'h1C, 8'h01);
		@(negedge core_clk_i);
		chk({6'h0, seq_sleep_o, seq_clk_en_o}, 8'h02);
		pulse(5'h02);
		chk({7'h0, seq_sleep_o}, 8'h00);
		rd(10'h070, 8'h00);
		seq.put(8'h1C, 8'h02);
		pulse(5'h01);
		chk({7'h0, seq_sleep_o}, 8'h01);
		pulse(5'h08);
		chk({7'h0, seq_sleep_o}, 8'h00);
		seq.put(8'h1C, 8'h01);
		pulse(5'h09);
		chk({7'h0, seq_sleep_o}, 8'h00);
		seq.put(8'h1C, 8'h01);
		pulse(5'h10);
		chk({7'h0, seq_sleep_o}, 8'h00);
		rd(10'h070, 8'h00);
		bus(1'b1, 10'h070, 8'h80);
		seq.put(8'h1C, 8'h03);
		@(negedge core_clk_i);
		chk({7'h0, seq_sleep_o}, 8'h00);
		rd(10'h070, 8'h80);
		$display("test sleep done");
		end_sim();
	end
endmodule

// File: bench/cqs_regs_chk.sv
// concurrent checks on the completion queue and sleep register group ports
`timescale 1ns/100ps
module cqs_regs_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic seq_wr_i,
	input wire logic external_cmdblock_ram_mode_i,
	input wire logic host_pause_off_wr_i,
	input wire logic dma_complete_i,
	input wire logic phase_mismatch_i,
	input wire logic select_out_done_i,
	input wire logic select_in_done_i,
	input wire logic seq_sleep_o,
	input wire logic seq_clk_en_o,
	input wire logic internal_io_bus_idle_o,
	input wire logic cmdblock_in_ext_sram_o,
	input wire logic [2:0] special_function_mode_o,
	input wire logic [2:0] special_function_flags_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// asleep with no sequencer write pending, so only wake causes act
	sequence s_quiet_sleep;
		seq_sleep_o && !seq_wr_i;
	endsequence
	// the host is answered after exactly one wait state, sequencer busy or not
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not released after one wait state");
	clk_gate_a: assert property (seq_clk_en_o == !seq_sleep_o)
		else $error("sequencer clock enable disagrees with sleep");
	bus_idle_a: assert property (internal_io_bus_idle_o == seq_sleep_o)
		else $error("internal bus idle disagrees with sleep");
	ext_sram_a: assert property (cmdblock_in_ext_sram_o == external_cmdblock_ram_mode_i)
		else $error("command block storage select wrong");
	sleep_cause_a: assert property ($rose(seq_sleep_o) |-> $past(seq_wr_i))
		else $error("sleep entered without a sequencer write");
	wake_status_a: assert property (s_quiet_sleep ##0 (dma_complete_i && select_in_done_i)
		|=> !seq_sleep_o)
		else $error("selected status did not wake the sequencer");
	pause_off_a: assert property (s_quiet_sleep ##0 host_pause_off_wr_i |=> !seq_sleep_o)
		else $error("pause-off write did not end sleep");
	sf_split_a: assert property (special_function_mode_o == 3'h0 || special_function_flags_o == 3'h0)
		else $error("function bits act as mode and flags at once");
	queue_nibble_a: assert property (avs_read && !avs_waitrequest && avs_address == 10'h274
		&& !external_cmdblock_ram_mode_i |-> avs_readdata[7:4] == 4'h0)
		else $error("queue read upper nibble not zero in internal mode");
endmodule
bind cqs_regs cqs_regs_chk u_chk (.*);

// File: bench/cqs_seq_model.sv
// embedded sequencer model driving the sequencer register port
`timescale 1ns/100ps
module cqs_seq_model (
	input wire logic core_clk_i,
	input wire logic seq_clk_en_i,
	output logic seq_wr_o,
	output logic [7:0] seq_addr_o,
	output logic [7:0] seq_wdata_o
);
	// idle lines
	initial begin
		seq_wr_o = 1'b0;
		seq_addr_o = 8'h00;
		seq_wdata_o = 8'h00;
	end
	// one register write; idle lines show the inverse so stale data never looks valid
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		while (seq_clk_en_i !== 1'b1) @(posedge core_clk_i); // a stalled core issues nothing
		seq_wr_o <= 1'b1;
		seq_addr_o <= a;
		seq_wdata_o <= d;
		@(posedge core_clk_i);
		seq_wr_o <= 1'b0;
		seq_addr_o <= ~a;
		seq_wdata_o <= ~d;
	endtask
endmodule

// File: logic/cqs_done_queue.sv
// first-in first-out store of completed command-block pointers
`timescale 1ns/100ps
module cqs_done_queue (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ext_mode_i,
	input wire logic push_i,
	input wire logic [7:0] push_data_i,
	input wire logic pop_i,
	output logic [7:0] head_o,
	output logic [7:0] count_o
);

	logic [7:0] mem [cqs_pkg::Q_WORDS];
	logic [cqs_pkg::Q_ADDR_W-1:0] wr_ptr_q;
	logic [cqs_pkg::Q_ADDR_W-1:0] wr_ptr_d;
	logic [cqs_pkg::Q_ADDR_W-1:0] rd_ptr_q;
	logic [cqs_pkg::Q_ADDR_W-1:0] rd_ptr_d;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic mode_q;
	logic [7:0] cap;
	logic [7:0] idx_mask;
	logic push_ok;
	logic pop_ok;
	logic mode_flip;

	// internal mode keeps only sixteen slots; external mode keeps up to 255 of the 256 slots
	assign cap = ext_mode_i ? cqs_pkg::Q_CAP_EXTERNAL : cqs_pkg::Q_CAP_INTERNAL;
	assign idx_mask = ext_mode_i ? cqs_pkg::Q_IDX_MASK_EXTERNAL : cqs_pkg::Q_IDX_MASK_INTERNAL;
	// full or empty requests leave every pointer and the count alone
	assign push_ok = push_i && (count_q != cqs_pkg::Q_CAP_EXTERNAL) && (count_q < cap);
	assign pop_ok = pop_i && (count_q != 8'h00);
	// a mode change remaps storage, so the old contents are dropped
	assign mode_flip = (mode_q != ext_mode_i);

	// pointers wrap at 256, a multiple of 16, so masking keeps them consistent
	assign wr_ptr_d = mode_flip ? 8'h00 : (push_ok ? wr_ptr_q + 8'h01 : wr_ptr_q);
	assign rd_ptr_d = mode_flip ? 8'h00 : (pop_ok ? rd_ptr_q + 8'h01 : rd_ptr_q);
	assign count_d = mode_flip ? 8'h00 :
		(push_ok && !pop_ok) ? count_q + 8'h01 :
		(pop_ok && !push_ok) ? count_q - 8'h01 : count_q;

	// oldest entry, with the upper nibble hidden in internal mode; an empty queue
	// reads as the reset value so unwritten storage never reaches the bus
	assign head_o = (count_q == 8'h00) ? cqs_pkg::RST_DONE_QUEUE_PORT :
		(mem[rd_ptr_q & idx_mask] &
		(ext_mode_i ? 8'hFF : cqs_pkg::Q_DATA_MASK_INTERNAL));
	assign count_o = count_q;

	// storage array, no reset needed since count guards every read
	always_ff @(posedge core_clk_i) begin
		if (push_ok && !mode_flip) begin
			mem[wr_ptr_q & idx_mask] <= push_data_i;
		end
	end

	// pointer and count state
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= 8'h00;
			rd_ptr_q <= 8'h00;
			count_q <= cqs_pkg::RST_DONE_QUEUE_COUNT;
			mode_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			mode_q <= ext_mode_i;
		end
	end

endmodule

// File: logic/cqs_pkg.sv
// constants for the completion queue and sleep control register group
package cqs_pkg;

	// register indices; the avalon byte address is four times the index
	localparam logic [7:0] IDX_SLEEP_CONTROL = 8'h1C;
	localparam logic [7:0] IDX_DONE_QUEUE_PORT = 8'h9D;
	localparam logic [7:0] IDX_DONE_QUEUE_COUNT = 8'h9E;
	localparam logic [7:0] IDX_SPECIAL_FUNCTION = 8'h9F;

	// reset values
	localparam logic [7:0] RST_SLEEP_CONTROL = 8'h00;
	localparam logic [7:0] RST_DONE_QUEUE_PORT = 8'h00;
	localparam logic [7:0] RST_DONE_QUEUE_COUNT = 8'h00;
	localparam logic [7:0] RST_SPECIAL_FUNCTION = 8'h00;

	// sleep_control fields
	localparam int SLP_INHIBIT_BIT = 7;
	localparam int SLP_DMA_PHASE_BIT = 1;
	localparam int SLP_SELECTION_BIT = 0;
	localparam logic [7:0] SLP_READ_MASK = 8'h83;

	// special_function_select fields
	localparam int SF_FLAG_LSB = 5;
	localparam int SF_FLAG_MSB = 7;
	localparam int SF_TEST_MSB = 4;
	localparam int SF_RAM_STRESS_BIT = 4;
	localparam int SF_HOST_BIT = 3;
	localparam int SF_SEQ_BIT = 2;
	localparam int SF_FIFO_BIT = 1;
	localparam int SF_SCSI_BIT = 0;

	// completion queue geometry
	localparam int Q_ADDR_W = 8;
	localparam int Q_WORDS = 256;
	localparam logic [7:0] Q_CAP_INTERNAL = 8'h10;
	localparam logic [7:0] Q_CAP_EXTERNAL = 8'hFF;
	localparam logic [7:0] Q_IDX_MASK_INTERNAL = 8'h0F;
	localparam logic [7:0] Q_IDX_MASK_EXTERNAL = 8'hFF;
	localparam logic [7:0] Q_DATA_MASK_INTERNAL = 8'h0F;

	// avalon slave handshake states, gray along the path
	typedef enum logic [1:0] {
		CQS_BUS_IDLE = 2'b00,
		CQS_BUS_ANSWER = 2'b01
	} cqs_bus_state_t;

endpackage

// File: logic/cqs_regs.sv
// completion queue, special function and sequencer sleep register group
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
module cqs_regs (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// sequencer register port
	input wire logic seq_wr_i,
	input wire logic [7:0] seq_addr_i,
	input wire logic [7:0] seq_wdata_i,
	output logic [7:0] seq_rdata_o,
	// mode and host pause-control event
	input wire logic external_cmdblock_ram_mode_i,
	input wire logic host_pause_off_wr_i,
	// wake status
	input wire logic dma_complete_i,
	input wire logic phase_mismatch_i,
	input wire logic select_out_done_i,
	input wire logic select_in_done_i,
	// sleep effects and command block storage select
	output logic seq_sleep_o,
	output logic seq_clk_en_o,
	output logic internal_io_bus_idle_o,
	output logic cmdblock_in_ext_sram_o,
	// test selections, mode and flags
	output logic seq_ram_stress_test_o,
	output logic host_block_test_o,
	output logic sequencer_block_test_o,
	output logic data_fifo_test_o,
	output logic scsi_block_test_o,
	output logic [2:0] special_function_mode_o,
	output logic [2:0] special_function_flags_o
);

	// register read mux shared by host bus and sequencer readback
	function automatic logic [7:0] cqs_read_mux(
		input logic [7:0] idx,
		input logic [7:0] sleep_r,
		input logic [7:0] head_r,
		input logic [7:0] count_r,
		input logic [7:0] sf_r
	);
		logic [7:0] val;
		val = 8'h00;
		unique case (idx)
			cqs_pkg::IDX_SLEEP_CONTROL: val = sleep_r & cqs_pkg::SLP_READ_MASK;
			cqs_pkg::IDX_DONE_QUEUE_PORT: val = head_r;
			cqs_pkg::IDX_DONE_QUEUE_COUNT: val = count_r;
			cqs_pkg::IDX_SPECIAL_FUNCTION: val = sf_r;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	cqs_pkg::cqs_bus_state_t bus_state_q;
	cqs_pkg::cqs_bus_state_t bus_state_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] seq_rdata_q;
	logic [7:0] seq_rdata_d;
	logic sleep_inhibit_q;
	logic sleep_inhibit_d;
	logic [1:0] wake_en_q;
	logic [1:0] wake_en_d;
	logic [7:0] special_function_select_q;
	logic [7:0] special_function_select_d;
	logic sleeping_q;
	logic [7:0] sleep_reg;
	logic [7:0] q_head;
	logic [7:0] q_count;

	// host bus decode
	logic bus_req;
	logic bus_first;
	logic bus_commit;
	logic [7:0] bus_idx;
	logic bus_idx_hi_zero;
	logic [7:0] bus_idx_ok;
	logic host_wr;
	logic host_wr_sleep;
	logic host_wr_special_function_select;
	logic host_pop;

	// sequencer decode
	logic seq_wr_queue;
	logic seq_wr_sleep;
	logic seq_wr_special_function_select;
	logic [1:0] seq_wake_req;

	// sleep and wake terms
	logic wake_dma_phase;
	logic wake_selection;
	logic wake_hit;
	logic [1:0] wake_set;
	logic [1:0] wake_clr;

	// special function terms
	logic any_test;

	// address: index lives in bits 9:2, the two low bits must be zero
	assign bus_req = avs_read || avs_write;
	assign bus_idx_hi_zero = (avs_address[1:0] == 2'b00);
	assign bus_idx = avs_address[9:2];
	assign bus_idx_ok = bus_idx_hi_zero ? bus_idx : 8'h00;
	// a request is seen in its first cycle and committed in the answer cycle
	assign bus_first = bus_req && (bus_state_q == cqs_pkg::CQS_BUS_IDLE);
	assign bus_commit = bus_req && (bus_state_q == cqs_pkg::CQS_BUS_ANSWER);
	assign avs_waitrequest = bus_req && (bus_state_q == cqs_pkg::CQS_BUS_IDLE);
	assign avs_readdata = rdata_q;

	// host writes land in the answer cycle, only through byte lane 0
	assign host_wr = bus_commit && avs_write && avs_byteenable[0];
	assign host_wr_sleep = host_wr && (bus_idx_ok == cqs_pkg::IDX_SLEEP_CONTROL) &&
		bus_idx_hi_zero;
	assign host_wr_special_function_select = host_wr && (bus_idx_ok == cqs_pkg::IDX_SPECIAL_FUNCTION) &&
		bus_idx_hi_zero;
	// pop once, in the cycle the read data are captured; no pause needed
	assign host_pop = bus_first && avs_read && bus_idx_hi_zero &&
		(bus_idx == cqs_pkg::IDX_DONE_QUEUE_PORT);

	// handshake state
	always_comb begin
		bus_state_d = bus_state_q;
		unique case (bus_state_q)
			cqs_pkg::CQS_BUS_IDLE: begin
				if (bus_req) begin
					bus_state_d = cqs_pkg::CQS_BUS_ANSWER;
				end
			end
			cqs_pkg::CQS_BUS_ANSWER: begin
				bus_state_d = cqs_pkg::CQS_BUS_IDLE;
			end
			default: begin
				bus_state_d = cqs_pkg::CQS_BUS_IDLE;
			end
		endcase
	end

	// read data are taken in the first cycle so they stand with waitrequest low
	assign rdata_d = (bus_first && avs_read) ?
		{24'h000000, cqs_read_mux(bus_idx_ok, sleep_reg, q_head, q_count, special_function_select_q)} :
		rdata_q;

	// sequencer register decode
	assign seq_wr_queue = seq_wr_i && (seq_addr_i == cqs_pkg::IDX_DONE_QUEUE_PORT);
	assign seq_wr_sleep = seq_wr_i && (seq_addr_i == cqs_pkg::IDX_SLEEP_CONTROL);
	assign seq_wr_special_function_select = seq_wr_i && (seq_addr_i == cqs_pkg::IDX_SPECIAL_FUNCTION);
	assign seq_wake_req = {seq_wdata_i[cqs_pkg::SLP_DMA_PHASE_BIT],
		seq_wdata_i[cqs_pkg::SLP_SELECTION_BIT]};
	// sequencer readback never pops; only a host read or a mode change removes entries
	assign seq_rdata_d = cqs_read_mux(seq_addr_i, sleep_reg, q_head, q_count, special_function_select_q);
	assign seq_rdata_o = seq_rdata_q;

	// completion queue storage
	cqs_done_queue u_done_queue (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ext_mode_i(external_cmdblock_ram_mode_i),
		.push_i(seq_wr_queue),
		.push_data_i(seq_wdata_i),
		.pop_i(host_pop),
		.head_o(q_head),
		.count_o(q_count)
	);

	// in external mode the command blocks move off chip
	assign cmdblock_in_ext_sram_o = external_cmdblock_ram_mode_i;

	// wake status selection per enable bit
	assign wake_dma_phase = wake_en_q[1] && (dma_complete_i || phase_mismatch_i);
	assign wake_selection = wake_en_q[0] && (select_out_done_i || select_in_done_i);
	assign wake_hit = wake_dma_phase || wake_selection;

	// inhibit blocks the set, so the sequencer just carries on
	assign wake_set = (seq_wr_sleep && !sleep_inhibit_q) ? seq_wake_req : 2'b00;
	// wake or a host pause-off write clears both enables
	assign wake_clr = (wake_hit || host_pause_off_wr_i) ? 2'b11 : 2'b00;
	// a fresh set wins over a clear landing in the same cycle
	assign wake_en_d = wake_set | (wake_en_q & ~wake_clr);

	// inhibit belongs to the host driver
	assign sleep_inhibit_d = host_wr_sleep ? avs_writedata[cqs_pkg::SLP_INHIBIT_BIT] :
		sleep_inhibit_q;
	assign sleep_reg = {sleep_inhibit_q, 5'b00000, wake_en_q};

	// host wins when both sides write the function register together
	assign special_function_select_d = host_wr_special_function_select ? avs_writedata[7:0] :
		(seq_wr_special_function_select ? seq_wdata_i : special_function_select_q);

	// sleep effects derive from the enable bits, held in flops for clean gating
	assign seq_sleep_o = sleeping_q;
	assign seq_clk_en_o = !sleeping_q;
	assign internal_io_bus_idle_o = sleeping_q;

	// test selects drive the test logic directly
	assign seq_ram_stress_test_o = special_function_select_q[cqs_pkg::SF_RAM_STRESS_BIT];
	assign host_block_test_o = special_function_select_q[cqs_pkg::SF_HOST_BIT];
	assign sequencer_block_test_o = special_function_select_q[cqs_pkg::SF_SEQ_BIT];
	assign data_fifo_test_o = special_function_select_q[cqs_pkg::SF_FIFO_BIT];
	assign scsi_block_test_o = special_function_select_q[cqs_pkg::SF_SCSI_BIT];
	// upper bits are the mode next to an active test bit, the flags otherwise
	assign any_test = |special_function_select_q[cqs_pkg::SF_TEST_MSB:0];
	assign special_function_mode_o = any_test ?
		special_function_select_q[cqs_pkg::SF_FLAG_MSB:cqs_pkg::SF_FLAG_LSB] : 3'b000;
	assign special_function_flags_o = any_test ? 3'b000 :
		special_function_select_q[cqs_pkg::SF_FLAG_MSB:cqs_pkg::SF_FLAG_LSB];

	// bus handshake and read data
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state_q <= cqs_pkg::CQS_BUS_IDLE;
			rdata_q <= 32'h00000000;
		end else begin
			bus_state_q <= bus_state_d;
			rdata_q <= rdata_d;
		end
	end

	// sleep control and special function registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_inhibit_q <= cqs_pkg::RST_SLEEP_CONTROL[cqs_pkg::SLP_INHIBIT_BIT];
			wake_en_q <= cqs_pkg::RST_SLEEP_CONTROL[1:0];
			special_function_select_q <= cqs_pkg::RST_SPECIAL_FUNCTION;
		end else begin
			sleep_inhibit_q <= sleep_inhibit_d;
			wake_en_q <= wake_en_d;
			special_function_select_q <= special_function_select_d;
		end
	end

	// sleep flag is taken from the next enables, so it changes on the same edge as they settle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleeping_q <= 1'b0;
			seq_rdata_q <= 8'h00;
		end else begin
			sleeping_q <= |wake_en_d;
			seq_rdata_q <= seq_rdata_d;
		end
	end

endmodule
